// ==== common/charger_pkg.sv ====
// Constants, field positions and types shared by the charger command block
`default_nettype none
package charger_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam longint MINUTE_NS = 64'd60_000_000_000;
	localparam int MINUTE_CYCLES = int'(MINUTE_NS / CLK_PERIOD_NS);
	localparam int TIMEOUT_BASE_MIN = 5;
	localparam int MINUTES_W = 10;
	// ------------------------------------------------------------
	// Command word, index = position minus one
	// ------------------------------------------------------------
	localparam int CMD_BITS = 22;
	localparam int IDX_MODE_B0 = 1;
	localparam int IDX_MODE_B1 = 2;
	localparam int IDX_CONV = 3;
	localparam int IDX_ORDER = 4;
	localparam int IDX_INSEL_LO = 5;
	localparam int IDX_INSEL_HI = 7;
	localparam int IDX_ATTEN_LO = 8;
	localparam int IDX_ATTEN_HI = 11;
	localparam int IDX_SHUTDOWN = 12;
	localparam int IDX_DUTY_LO = 13;
	localparam int IDX_DUTY_HI = 15;
	localparam int IDX_CLEAR = 16;
	localparam int IDX_TIMEOUT_LO = 17;
	localparam int IDX_TIMEOUT_HI = 19;
	localparam int IDX_REF_LO = 20;
	localparam int IDX_REF_HI = 21;
	localparam logic [CMD_BITS-1:1] CMD_RESET = 21'h0;
	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_DISCHARGE = 2'h1;
	localparam logic [1:0] MODE_CHARGE = 2'h2;
	localparam logic [1:0] MODE_GAUGE = 2'h3;
	localparam logic [2:0] TIMEOUT_NONE = 3'h7;
	localparam logic [2:0] DUTY_FULL = 3'h4;
	localparam logic [2:0] INSEL_MAX = 3'h4;
	localparam logic [7:0] REF_MV_0 = 8'h12;
	localparam logic [7:0] REF_MV_1 = 8'h22;
	localparam logic [7:0] REF_MV_2 = 8'h37;
	localparam logic [7:0] REF_MV_3 = 8'ha0;
	// ------------------------------------------------------------
	// Status word bits
	// ------------------------------------------------------------
	localparam int STATUS_BITS = 8;
	localparam int ST_PRESENT = 0;
	localparam int ST_REVERSED = 1;
	localparam int ST_OVER_CELL = 2;
	localparam int ST_END_DIS = 3;
	localparam int ST_OVER_TEMP = 4;
	localparam int ST_UNDER_TEMP = 5;
	localparam int ST_TIMEOUT = 6;
	localparam int ST_FAULT = 7;
	localparam int CMP_BITS = 6;
	typedef enum logic [1:0] {LINK_IDLE, LINK_HUNT, LINK_CMD, LINK_STATUS}
		link_state_e;
endpackage
`default_nettype wire

// ==== src/failsafe_monitor.sv ====
// Fail-safe timer, fault latches and drive gating
`default_nettype none
module failsafe_monitor #(
	parameter int MINUTE_CYCLES = charger_pkg::MINUTE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic fault_clear,
	input wire logic [1:0] op_mode,
	input wire logic power_shutdown,
	input wire logic [2:0] timeout_sel,
	input wire logic battery_present,
	input wire logic battery_reversed,
	input wire logic cell_over_max,
	input wire logic cell_end_discharge,
	input wire logic over_temp,
	input wire logic under_temp,
	output logic timeout_flag,
	output logic fault_occurred,
	output logic discharge_drive,
	output logic charge_drive
);
	if (MINUTE_CYCLES < 1)
	begin : g_bad_minute
		$error("MINUTE_CYCLES must be at least one");
	end
	localparam int MW = charger_pkg::MINUTES_W;
	logic [31:0] tick_q, tick_d;
	logic [MW-1:0] minutes_q, minutes_d;
	logic tout_q, tout_d, fs_q, fs_d, dis_q, dis_d, chg_q, chg_d;
	logic act_dis, act_chg, timed_out, fault_dis, fault_chg, blocked;
	logic [MW-1:0] limit;
	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		act_dis = !power_shutdown
			&& op_mode == charger_pkg::MODE_DISCHARGE;
		act_chg = !power_shutdown
			&& op_mode == charger_pkg::MODE_CHARGE;
		limit = MW'(charger_pkg::TIMEOUT_BASE_MIN) << timeout_sel;
		timed_out = timeout_sel != charger_pkg::TIMEOUT_NONE
			&& minutes_q >= limit;
		fault_dis = cell_end_discharge | over_temp | under_temp | tout_q
			| timed_out;
		fault_chg = cell_over_max | over_temp | under_temp | tout_q
			| timed_out;
		blocked = !battery_present | battery_reversed;
		tick_d = tick_q;
		minutes_d = minutes_q;
		if (fault_clear)
		begin
			tick_d = 32'h0;
			minutes_d = '0;
		end
		else if ((act_dis || act_chg) && !fs_q)
		begin
			if (tick_q == 32'(MINUTE_CYCLES - 1))
			begin
				tick_d = 32'h0;
				if (minutes_q != '1)
					minutes_d = minutes_q + MW'(1);
			end
			else
				tick_d = tick_q + 32'h1;
		end
		tout_d = (fault_clear ? 1'b0 : tout_q) | timed_out;
		fs_d = (fault_clear ? 1'b0 : fs_q) | (act_dis && fault_dis)
			| (act_chg && fault_chg);
		dis_d = act_dis && !fault_dis && !fs_q && !blocked;
		chg_d = act_chg && !fault_chg && !fs_q && !blocked;
	end
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_q <= 32'h0;
			minutes_q <= '0;
			tout_q <= 1'b0;
			fs_q <= 1'b0;
			dis_q <= 1'b0;
			chg_q <= 1'b0;
		end
		else
		begin
			tick_q <= tick_d;
			minutes_q <= minutes_d;
			tout_q <= tout_d;
			fs_q <= fs_d;
			dis_q <= dis_d;
			chg_q <= chg_d;
		end
	end
	assign timeout_flag = tout_q;
	assign fault_occurred = fs_q;
	assign discharge_drive = dis_q;
	assign charge_drive = chg_q;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_fs_sticky: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		fs_q && !fault_clear |=> fs_q)
		else $error("fault flag dropped without clear");
	a_clear_timer: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		fault_clear |=> minutes_q == '0 && tick_q == 32'h0)
		else $error("clear did not reset timer");
	a_no_timeout_code: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		timeout_sel == charger_pkg::TIMEOUT_NONE && !tout_q |=> !tout_q)
		else $error("timeout raised while disabled");
	a_fault_no_drive: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(fs_q || blocked) |=> !dis_q && !chg_q)
		else $error("drive on during fault");
	a_shutdown_no_drive: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		power_shutdown [*2] |-> !dis_q && !chg_q)
		else $error("drive on in shutdown");
endmodule
`default_nettype wire

// ==== src/charger_command_status_decode.sv ====
// Serial command decode and status word for the battery charger controller
`default_nettype none
module charger_command_status_decode #(
	parameter int MINUTE_CYCLES = charger_pkg::MINUTE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ser_clk,
	input wire logic cs_n,
	input wire logic ser_din,
	output logic ser_dout,
	output logic ser_dout_oe,
	input wire logic battery_present_cmp,
	input wire logic cell_below_100mv_cmp,
	input wire logic cell_above_max_cmp,
	input wire logic cell_below_900mv_cmp,
	input wire logic tbat_below_high_cmp,
	input wire logic tbat_above_low_cmp,
	output logic [1:0] op_mode,
	output logic power_shutdown_bit,
	output logic conversion_type_sel,
	output logic result_bit_order,
	output logic [2:0] adc_input_sel,
	output logic adc_input_sel_valid,
	output logic [3:0] atten_ratio,
	output logic [4:0] atten_divisor,
	output logic [2:0] loop_duty,
	output logic loop_duty_full,
	output logic loop_duty_test,
	output logic fault_clear_bit,
	output logic [2:0] timeout_sel,
	output logic [1:0] charge_ref,
	output logic [7:0] charge_ref_mv,
	output logic [7:0] fault_status_report,
	output logic discharge_drive,
	output logic charge_drive
);
	localparam int NB = charger_pkg::CMD_BITS;
	localparam int CB = charger_pkg::CMP_BITS;
	if (MINUTE_CYCLES < 1)
	begin : g_bad_minute
		$error("MINUTE_CYCLES must be at least one");
	end
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic sclk_m_q, sclk_s_q, sclk_p_q, cs_m_q, cs_s_q, din_m_q, din_s_q;
	logic [CB-1:0] cmp_m_q, cmp_s_q;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_m_q <= 1'b0;
			sclk_s_q <= 1'b0;
			sclk_p_q <= 1'b0;
			cs_m_q <= 1'b1;
			cs_s_q <= 1'b1;
			din_m_q <= 1'b0;
			din_s_q <= 1'b0;
			cmp_m_q <= '0;
			cmp_s_q <= '0;
		end
		else
		begin
			sclk_m_q <= ser_clk;
			sclk_s_q <= sclk_m_q;
			sclk_p_q <= sclk_s_q;
			cs_m_q <= cs_n;
			cs_s_q <= cs_m_q;
			din_m_q <= ser_din;
			din_s_q <= din_m_q;
			cmp_m_q <= {tbat_above_low_cmp, tbat_below_high_cmp,
				cell_below_900mv_cmp, cell_above_max_cmp,
				cell_below_100mv_cmp, battery_present_cmp};
			cmp_s_q <= cmp_m_q;
		end
	end
	logic sclk_rise, sclk_fall;
	assign sclk_rise = sclk_s_q & ~sclk_p_q;
	assign sclk_fall = ~sclk_s_q & sclk_p_q;
	// ------------------------------------------------------------
	// Serial command and status engine
	// ------------------------------------------------------------
	charger_pkg::link_state_e state_q, state_d;
	logic [4:0] pos_q, pos_d;
	logic [3:0] out_cnt_q, out_cnt_d;
	logic [NB-1:1] cmd_q, cmd_d;
	logic [7:0] shift_q, shift_d;
	logic dout_q, dout_d;
	logic [7:0] status_word;
	always_comb
	begin
		state_d = state_q;
		pos_d = pos_q;
		out_cnt_d = out_cnt_q;
		cmd_d = cmd_q;
		shift_d = shift_q;
		dout_d = dout_q;
		if (cs_s_q)
		begin
			state_d = charger_pkg::LINK_IDLE;
			pos_d = 5'h0;
			cmd_d[charger_pkg::IDX_CLEAR] = 1'b0;
		end
		else
		begin
			unique case (state_q)
				charger_pkg::LINK_IDLE:
					state_d = charger_pkg::LINK_HUNT;
				charger_pkg::LINK_HUNT:
					if (sclk_rise && din_s_q)
					begin
						state_d = charger_pkg::LINK_CMD;
						pos_d = 5'h1;
					end
				charger_pkg::LINK_CMD:
					if (sclk_rise)
					begin
						cmd_d[pos_q] = din_s_q;
						if (pos_q == 5'(NB - 1))
						begin
							state_d = charger_pkg::LINK_STATUS;
							shift_d = status_word;
							out_cnt_d = 4'h0;
						end
						else
							pos_d = pos_q + 5'h1;
					end
				charger_pkg::LINK_STATUS:
					if (sclk_fall && out_cnt_q != 4'(charger_pkg::STATUS_BITS))
					begin
						dout_d = shift_q[0];
						shift_d = {1'b0, shift_q[7:1]};
						out_cnt_d = out_cnt_q + 4'h1;
					end
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= charger_pkg::LINK_IDLE;
			pos_q <= 5'h0;
			out_cnt_q <= 4'h0;
			cmd_q <= charger_pkg::CMD_RESET;
			shift_q <= 8'h0;
			dout_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			pos_q <= pos_d;
			out_cnt_q <= out_cnt_d;
			cmd_q <= cmd_d;
			shift_q <= shift_d;
			dout_q <= dout_d;
		end
	end
	assign ser_dout = dout_q;
	assign ser_dout_oe = ~cs_s_q;
	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	assign op_mode = cmd_q[charger_pkg::IDX_MODE_B1:charger_pkg::IDX_MODE_B0];
	assign power_shutdown_bit = cmd_q[charger_pkg::IDX_SHUTDOWN];
	assign conversion_type_sel = cmd_q[charger_pkg::IDX_CONV];
	assign result_bit_order = cmd_q[charger_pkg::IDX_ORDER];
	assign adc_input_sel =
		cmd_q[charger_pkg::IDX_INSEL_HI:charger_pkg::IDX_INSEL_LO];
	assign adc_input_sel_valid = adc_input_sel <= charger_pkg::INSEL_MAX;
	assign atten_ratio =
		cmd_q[charger_pkg::IDX_ATTEN_HI:charger_pkg::IDX_ATTEN_LO];
	assign atten_divisor = {1'b0, atten_ratio} + 5'h1;
	assign loop_duty = cmd_q[charger_pkg::IDX_DUTY_HI:charger_pkg::IDX_DUTY_LO];
	assign loop_duty_full = loop_duty == charger_pkg::DUTY_FULL;
	assign loop_duty_test = loop_duty > charger_pkg::DUTY_FULL;
	assign fault_clear_bit = cmd_q[charger_pkg::IDX_CLEAR];
	assign timeout_sel =
		cmd_q[charger_pkg::IDX_TIMEOUT_HI:charger_pkg::IDX_TIMEOUT_LO];
	assign charge_ref = cmd_q[charger_pkg::IDX_REF_HI:charger_pkg::IDX_REF_LO];
	always_comb
	begin
		unique case (charge_ref)
			2'h0: charge_ref_mv = charger_pkg::REF_MV_0;
			2'h1: charge_ref_mv = charger_pkg::REF_MV_1;
			2'h2: charge_ref_mv = charger_pkg::REF_MV_2;
			2'h3: charge_ref_mv = charger_pkg::REF_MV_3;
		endcase
	end
	// ------------------------------------------------------------
	// Fail-safe and status
	// ------------------------------------------------------------
	logic timeout_flag, fault_occurred_flag;
	failsafe_monitor #(
		.MINUTE_CYCLES(MINUTE_CYCLES)
	) u_failsafe (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.fault_clear(fault_clear_bit),
		.op_mode(op_mode),
		.power_shutdown(power_shutdown_bit),
		.timeout_sel(timeout_sel),
		.battery_present(cmp_s_q[charger_pkg::ST_PRESENT]),
		.battery_reversed(cmp_s_q[charger_pkg::ST_REVERSED]),
		.cell_over_max(cmp_s_q[charger_pkg::ST_OVER_CELL]),
		.cell_end_discharge(cmp_s_q[charger_pkg::ST_END_DIS]),
		.over_temp(cmp_s_q[charger_pkg::ST_OVER_TEMP]),
		.under_temp(cmp_s_q[charger_pkg::ST_UNDER_TEMP]),
		.timeout_flag(timeout_flag),
		.fault_occurred(fault_occurred_flag),
		.discharge_drive(discharge_drive),
		.charge_drive(charge_drive)
	);
	assign status_word = {fault_occurred_flag, timeout_flag, cmp_s_q};
	assign fault_status_report = status_word;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence zero_while_hunting;
		state_q == charger_pkg::LINK_HUNT && !cs_s_q && sclk_rise && !din_s_q;
	endsequence
	sequence start_seen;
		state_q == charger_pkg::LINK_HUNT && !cs_s_q && sclk_rise && din_s_q;
	endsequence
	a_zero_skipped: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		zero_while_hunting |=> state_q != charger_pkg::LINK_CMD)
		else $error("leading zero taken as start");
	a_start_marker: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		start_seen |=> state_q == charger_pkg::LINK_CMD && pos_q == 5'h1)
		else $error("start marker missed");
	a_mode_pickoff: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		state_q == charger_pkg::LINK_CMD && !cs_s_q && sclk_rise
		&& pos_q == 5'(charger_pkg::IDX_MODE_B0)
		|=> op_mode[0] == $past(din_s_q))
		else $error("mode bit not applied on arrival");
	a_clear_on_deselect: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		cs_s_q |=> !fault_clear_bit)
		else $error("fault clear survived deselect");
	a_status_present: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		fault_status_report[charger_pkg::ST_PRESENT]
		== $past(cmp_m_q[charger_pkg::ST_PRESENT]))
		else $error("status present bit wrong");
endmodule
`default_nettype wire

// ==== sim/serial_host_model.sv ====
// Host side model that frames commands and reads back status
`default_nettype none
module serial_host_model (
	input wire logic core_clk,
	output logic cs_n,
	output logic ser_clk,
	output logic ser_din,
	input wire logic ser_dout,
	input wire logic ser_dout_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic dout_line;
	// Released line shows the inverse of the last driven bit
	assign dout_line = ser_dout_oe ? ser_dout : ~ser_dout;
	// ------------------------------------------------------------
	// Idle lines, link clock stands low
	// ------------------------------------------------------------
	initial
	begin
		cs_n = 1'b1;
		ser_clk = 1'b0;
		ser_din = 1'b1;
	end
	// ------------------------------------------------------------
	// Half link period of 400 ns
	// ------------------------------------------------------------
	task automatic half_bit();
		repeat (4) @(negedge core_clk);
	endtask
	// ------------------------------------------------------------
	// One transfer, leading zeros then command, then status
	// ------------------------------------------------------------
	task automatic frame(input logic [21:0] cmd, input int zeros,
		output logic [7:0] status, output logic oe_seen);
		@(negedge core_clk);
		cs_n = 1'b0;
		ser_din = 1'b0;
		half_bit();
		oe_seen = ser_dout_oe;
		for (int k = 0; k < zeros + 22; k++)
		begin
			if (k < zeros)
				ser_din = 1'b0;
			else
				ser_din = cmd[k - zeros];
			half_bit();
			ser_clk = 1'b1;
			half_bit();
			if (k < zeros + 21)
				ser_clk = 1'b0;
		end
		ser_din = ~ser_din;
		for (int j = 0; j < 8; j++)
		begin
			ser_clk = 1'b0;
			half_bit();
			ser_clk = 1'b1;
			half_bit();
			status[j] = dout_line;
		end
		cs_n = 1'b1;
		half_bit();
		ser_clk = 1'b0;
		half_bit();
	endtask
endmodule
`default_nettype wire

// ==== sim/charger_command_status_decode_bench.sv ====
// Self-checking bench for the charger command and status block
`default_nettype none
module charger_command_status_decode_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MIN_CYC = 100;
	logic core_clk, rst_n, cs_n, ser_clk, ser_din, ser_dout, ser_dout_oe;
	logic [5:0] cmp_in;
	logic [1:0] op_mode, charge_ref;
	logic power_shutdown_bit, conversion_type_sel, result_bit_order;
	logic [2:0] adc_input_sel, loop_duty, timeout_sel;
	logic adc_input_sel_valid, loop_duty_full, loop_duty_test;
	logic [3:0] atten_ratio;
	logic [4:0] atten_divisor;
	logic fault_clear_bit, discharge_drive, charge_drive;
	logic [7:0] charge_ref_mv, fault_status_report, status;
	logic oe_seen, saw_clr;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	// ------------------------------------------------------------
	// Design and host
	// ------------------------------------------------------------
	charger_command_status_decode #(
		.MINUTE_CYCLES(MIN_CYC)
	) charger_command_status_decode_i (
		.core_clk, .rst_n, .ser_clk, .cs_n, .ser_din, .ser_dout,
		.ser_dout_oe,
		.battery_present_cmp(cmp_in[0]),
		.cell_below_100mv_cmp(cmp_in[1]),
		.cell_above_max_cmp(cmp_in[2]),
		.cell_below_900mv_cmp(cmp_in[3]),
		.tbat_below_high_cmp(cmp_in[4]),
		.tbat_above_low_cmp(cmp_in[5]),
		.op_mode, .power_shutdown_bit, .conversion_type_sel,
		.result_bit_order, .adc_input_sel, .adc_input_sel_valid,
		.atten_ratio, .atten_divisor, .loop_duty, .loop_duty_full,
		.loop_duty_test, .fault_clear_bit, .timeout_sel, .charge_ref,
		.charge_ref_mv, .fault_status_report, .discharge_drive,
		.charge_drive
	);
	serial_host_model serial_host_model_i (
		.core_clk, .cs_n, .ser_clk, .ser_din, .ser_dout, .ser_dout_oe
	);
	// ------------------------------------------------------------
	// Clock, watchdog, clear monitor
	// ------------------------------------------------------------
	initial
		core_clk = 1'b0;
	always
		#50 core_clk = ~core_clk;
	always @(negedge core_clk)
	begin
		if (fault_clear_bit === 1'b1)
			saw_clr = 1'b1;
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			results();
		end
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic cmp(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [21:0] word(input logic [1:0] mode,
		input logic [2:0] insel, input logic [3:0] atten, input logic sd,
		input logic [2:0] duty, input logic clr, input logic [2:0] tmo,
		input logic [1:0] ref_sel, input logic conv, input logic order);
		return {ref_sel, tmo, clr, duty, sd, atten, insel, order, conv,
			mode, 1'b1};
	endfunction
	task automatic send(input logic [21:0] c, input int z);
		serial_host_model_i.frame(c, z, status, oe_seen);
		cmp("oe idle", 8'h0, {7'h0, ser_dout_oe});
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		cmp("timeout", 8'h0, {5'h0, timeout_sel});
		cmp("mode", 8'h0, {6'h0, op_mode});
		cmp("status", 8'h0, fault_status_report);
		cmp("drives", 8'h0, {6'h0, discharge_drive, charge_drive});
		$display("test reset done");
	endtask
	task automatic t_fields();
		logic [7:0] mv [4] = '{8'h12, 8'h22, 8'h37, 8'ha0};
		cmp_in = 6'h1;
		for (int i = 0; i < 8; i++)
		begin
			logic [2:0] sel;
			logic [3:0] at;
			sel = 3'(i % 5);
			at = (i == 7) ? 4'hf : 4'(i);
			send(word({i[0], i[0]}, sel, at, i[2], sel, 1'b0, 3'(i),
				2'(i % 4), i[0], i[1]), i);
			cmp("oe", 8'h1, {7'h0, oe_seen});
			cmp("mode", {6'h0, i[0], i[0]}, {6'h0, op_mode});
			cmp("conv", {7'h0, i[0]}, {7'h0, conversion_type_sel});
			cmp("order", {7'h0, i[1]}, {7'h0, result_bit_order});
			cmp("insel", {5'h0, sel}, {5'h0, adc_input_sel});
			cmp("insel ok", 8'h1, {7'h0, adc_input_sel_valid});
			cmp("divisor", 8'(at) + 8'h1, {3'h0, atten_divisor});
			cmp("ratio", 8'(at), {4'h0, atten_ratio});
			cmp("shutdown", {7'h0, i[2]}, {7'h0, power_shutdown_bit});
			cmp("duty", {5'h0, sel}, {5'h0, loop_duty});
			cmp("full", {7'h0, sel == 3'h4}, {7'h0, loop_duty_full});
			cmp("test", 8'h0, {7'h0, loop_duty_test});
			cmp("timeout", 8'(i), {5'h0, timeout_sel});
			cmp("ref", 8'(i % 4), {6'h0, charge_ref});
			cmp("ref mv", mv[i % 4], charge_ref_mv);
			cmp("drives", 8'h0, {6'h0, discharge_drive, charge_drive});
		end
		$display("test fields done");
	endtask
	task automatic t_status();
		for (int b = 0; b < 7; b++)
		begin
			@(negedge core_clk);
			cmp_in = (b < 6) ? 6'(1 << b) : 6'h0;
			send(word(2'h0, 3'h0, 4'h0, 1'b0, 3'h0, 1'b0, 3'h7, 2'h0,
				1'b0, 1'b0), 0);
			cmp("status", {2'h0, cmp_in}, status);
			cmp("report", {2'h0, cmp_in},
				fault_status_report);
		end
		$display("test status done");
	endtask
	task automatic t_fault();
		@(negedge core_clk);
		cmp_in = 6'h1;
		send(word(2'h1, 3'h3, 4'h0, 1'b0, 3'h4, 1'b0, 3'h7, 2'h0,
			1'b0, 1'b0), 0);
		wait_n(4);
		cmp("discharge", 8'h1, {7'h0, discharge_drive});
		cmp("charge", 8'h0, {7'h0, charge_drive});
		cmp_in = 6'h9;
		wait_n(6);
		cmp("drive fault", 8'h0, {7'h0, discharge_drive});
		cmp_in = 6'h1;
		wait_n(6);
		cmp("latch", 8'h1, {7'h0, fault_status_report[7]});
		cmp("drive held", 8'h0, {7'h0, discharge_drive});
		saw_clr = 1'b0;
		send(word(2'h1, 3'h3, 4'h0, 1'b0, 3'h4, 1'b1, 3'h7, 2'h0,
			1'b0, 1'b0), 0);
		cmp("clear seen", 8'h1, {7'h0, saw_clr});
		cmp("clear off", 8'h0, {7'h0, fault_clear_bit});
		cmp("unlatch", 8'h0, {7'h0, fault_status_report[7]});
		wait_n(4);
		cmp("discharge", 8'h1, {7'h0, discharge_drive});
		$display("test fault done");
	endtask
	task automatic t_timeout();
		send(word(2'h2, 3'h3, 4'h0, 1'b0, 3'h4, 1'b1, 3'h0, 2'h3,
			1'b0, 1'b1), 0);
		wait_n(4);
		cmp("charge", 8'h1, {7'h0, charge_drive});
		wait_n(5 * MIN_CYC - 40);
		cmp("early", 8'h0, {7'h0, fault_status_report[6]});
		wait_n(60);
		cmp("expired", 8'h1, {7'h0, fault_status_report[6]});
		cmp("latch", 8'h1, {7'h0, fault_status_report[7]});
		cmp("charge", 8'h0, {7'h0, charge_drive});
		send(word(2'h2, 3'h3, 4'h0, 1'b1, 3'h4, 1'b1, 3'h7, 2'h3,
			1'b0, 1'b1), 0);
		wait_n(4);
		cmp("cleared", 8'h0, {6'h0, fault_status_report[7:6]});
		cmp("shut", 8'h0, {7'h0, charge_drive});
		$display("test timeout done");
	endtask
	// ------------------------------------------------------------
	// Sequence and verdict
	// ------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		rst_n = 1'b0;
		cmp_in = 6'h0;
		saw_clr = 1'b0;
		wait_n(10);
		rst_n = 1'b1;
		wait_n(4);
		t_reset();
		t_fields();
		t_status();
		t_fault();
		t_timeout();
		results();
	end
endmodule
`default_nettype wire
